// [rtl/nvc_ctrl.v]
// host controller driving the nvsram pins: read, write, store, recall
// assumes the memory is clockless; data_io is tristate, resolved outside
`timescale 1ns/100ps
`default_nettype none
`include "nvc_map.vh"

module nvc_ctrl #(
    parameter [39:0] STORE_CYC   = `NVC_STORE_CYC,
    parameter [39:0] RECALL_CYC  = `NVC_RECALL_CYC,
    parameter [39:0] RESTORE_CYC = `NVC_RESTORE_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        cmd_valid,
    input  wire [1:0]  cmd_op,
    input  wire [12:0] cmd_addr,
    input  wire [7:0]  cmd_wdata,
    output reg         cmd_ready,
    output reg         rsp_valid,
    output reg  [7:0]  rsp_rdata,
    output reg  [12:0] byte_addr,
    output reg         chip_sel_n,
    output reg         out_en_n,
    output reg         wr_en_n,
    output reg         nv_sel_n,
    input  wire [7:0]  data_io_in,
    output reg  [7:0]  data_io_out,
    output reg         data_io_oe
);
    localparam [5:0] ST_BOOT = 6'h01;
    localparam [5:0] ST_IDLE = 6'h02;
    localparam [5:0] ST_SET  = 6'h04;
    localparam [5:0] ST_ACT  = 6'h08;
    localparam [5:0] ST_WAIT = 6'h10;
    localparam [5:0] ST_END  = 6'h20;

    reg [5:0]  state;
    reg [1:0]  op;
    reg [39:0] cnt;
    reg [7:0]  din_meta;
    reg [7:0]  din_sync;

    // counter limits widened to the counter width
    localparam [39:0] CNT_ZERO = `NVC_CNT_ZERO;
    localparam [39:0] CNT_STEP = `NVC_CNT_STEP;
    localparam [39:0] ACC_CYC  = {32'h0, `NVC_ACC_CYC};
    localparam [39:0] INIT_CYC = {32'h0, `NVC_INIT_CYC};

    // decoded operation and counter milestones
    wire       is_read;
    wire       is_write;
    wire       is_store;
    wire       is_recall;
    wire       is_nv;
    wire       acc_done;
    wire       init_done;
    wire       boot_done;
    wire       store_done;
    wire       recall_done;

    assign is_read     = (op == `NVC_CMD_READ);
    assign is_write    = (op == `NVC_CMD_WRITE);
    assign is_store    = (op == `NVC_CMD_STORE);
    assign is_recall   = (op == `NVC_CMD_RECALL);
    assign is_nv       = is_store | is_recall;
    assign acc_done    = (cnt >= ACC_CYC);
    assign init_done   = (cnt >= INIT_CYC);
    assign boot_done   = (cnt >= RESTORE_CYC);
    assign store_done  = (cnt >= STORE_CYC);
    assign recall_done = (cnt >= RECALL_CYC);

    // per-bit two-stage synchroniser; memory data is not timed to this clock
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                din_meta[gi] <= data_io_in[gi];
                din_sync[gi] <= din_meta[gi];
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_n) begin
            state       <= ST_BOOT;
            op          <= `NVC_CMD_READ;
            cnt         <= CNT_ZERO;
            cmd_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_rdata   <= `NVC_BYTE_RST;
            byte_addr   <= `NVC_ADDR_RST;
            chip_sel_n  <= 1'b1;
            out_en_n    <= 1'b1;
            wr_en_n     <= 1'b1;
            nv_sel_n    <= 1'b1;
            data_io_out <= `NVC_BYTE_RST;
            data_io_oe  <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                ST_BOOT: begin
                    // power-up copy runs inside the memory
                    if (boot_done) begin
                        cnt       <= CNT_ZERO;
                        cmd_ready <= 1'b1;
                        state     <= ST_IDLE;
                    end else begin
                        cnt <= cnt + CNT_STEP;
                    end
                end
                ST_IDLE: begin
                    chip_sel_n <= 1'b1;
                    data_io_oe <= 1'b0;
                    if (cmd_valid) begin
                        cmd_ready   <= 1'b0;
                        op          <= cmd_op;
                        byte_addr   <= cmd_addr;
                        data_io_out <= cmd_wdata;
                        cnt         <= CNT_ZERO;
                        // set up the non-final controls first
                        case (cmd_op)
                            `NVC_CMD_WRITE: begin
                                out_en_n   <= 1'b1;
                                nv_sel_n   <= 1'b1;
                                data_io_oe <= 1'b1;
                            end
                            `NVC_CMD_STORE: begin
                                out_en_n <= 1'b1;
                                nv_sel_n <= 1'b0;
                            end
                            `NVC_CMD_RECALL: begin
                                wr_en_n  <= 1'b1;
                                out_en_n <= 1'b0;
                                nv_sel_n <= 1'b0;
                            end
                            default: begin
                                nv_sel_n <= 1'b1;
                                out_en_n <= 1'b1;
                            end
                        endcase
                        state <= ST_SET;
                    end
                end
                ST_SET: begin
                    chip_sel_n <= 1'b0;
                    case (op)
                        `NVC_CMD_READ: out_en_n <= 1'b0;
                        default: ;
                    endcase
                    state <= ST_ACT;
                end
                ST_ACT: begin
                    // final falling signal triggers the operation
                    case (op)
                        `NVC_CMD_WRITE: wr_en_n <= 1'b0;
                        `NVC_CMD_STORE: wr_en_n <= 1'b0;
                        default: ;
                    endcase
                    cnt   <= CNT_ZERO;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    cnt <= cnt + CNT_STEP;
                    if (is_read && acc_done) begin
                        rsp_rdata <= din_sync;
                        out_en_n  <= 1'b1;
                        state     <= ST_END;
                    end
                    if (is_write && acc_done) begin
                        wr_en_n <= 1'b1;
                        state   <= ST_END;
                    end
                    if (is_nv && init_done) begin
                        // initiation satisfied, release controls
                        wr_en_n    <= 1'b1;
                        out_en_n   <= 1'b1;
                        nv_sel_n   <= 1'b1;
                        chip_sel_n <= 1'b1;
                    end
                    if (is_store && store_done) begin
                        state <= ST_END;
                    end
                    if (is_recall && recall_done) begin
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    // address and data held one cycle past write edge
                    chip_sel_n <= 1'b1;
                    data_io_oe <= 1'b0;
                    rsp_valid  <= 1'b1;
                    cmd_ready  <= 1'b1;
                    state      <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // nvc_ctrl
`default_nettype wire

// [rtl/nvc_map.vh]
// constants for the host-side nvsram controller
// assumes a 40 MHz controller clock
`ifndef NVC_MAP_VH
`define NVC_MAP_VH
`define NVC_CLK_NS          40'h19
`define NVC_INIT_NS         40'h19
`define NVC_INIT_CYC        8'h2
`define NVC_STORE_MS        40'hA
`define NVC_STORE_CYC       (`NVC_STORE_MS * 40'hF4240 / `NVC_CLK_NS)
`define NVC_RECALL_US       40'h14
`define NVC_RECALL_CYC      (`NVC_RECALL_US * 40'h3E8 / `NVC_CLK_NS)
`define NVC_RESTORE_CYC     (`NVC_RECALL_CYC)
`define NVC_ACC_CYC         8'h3
`define NVC_SETUP_CYC       8'h1
`define NVC_CNT_ZERO        40'h0
`define NVC_CNT_STEP        40'h1
`define NVC_ADDR_RST        13'h0000
`define NVC_BYTE_RST        8'h00
`define NVC_CMD_READ        2'h0
`define NVC_CMD_WRITE       2'h1
`define NVC_CMD_STORE       2'h2
`define NVC_CMD_RECALL      2'h3
`endif

// [bench/nvc_assertions.sv]
// pin-level checks on the nvsram host controller
// bound to nvc_ctrl, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module nvc_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cmd_ready,
    input wire logic        chip_sel_n,
    input wire logic        out_en_n,
    input wire logic        wr_en_n,
    input wire logic        nv_sel_n,
    input wire logic        data_io_oe,
    input wire logic [12:0] byte_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wr  = !chip_sel_n && !wr_en_n && nv_sel_n;
    wire sst = !nv_sel_n && !chip_sel_n && !wr_en_n && out_en_n;
    wire sgo = !wr_en_n && !nv_sel_n;
    a_read_no_we: assert property (!out_en_n |-> wr_en_n) else $error("write enable low with output on");
    a_wr_drive: assert property (wr |-> out_en_n && data_io_oe) else $error("write without data or with oe");
    a_addr_hold: assert property (wr ##1 wr |-> $stable(byte_addr)) else $error("address moved in write");
    a_we_last: assert property ($fell(wr_en_n) && !nv_sel_n |-> !chip_sel_n && out_en_n
        && $stable(nv_sel_n) && $stable(chip_sel_n)) else $error("store not entered by write enable");
    a_store_hold: assert property ($fell(wr_en_n) && !nv_sel_n |-> sst[*2]) else $error("store too short");
    a_store_quiet: assert property ($rose(sgo) |=> (!cmd_ready && !data_io_oe)[*8])
        else $error("activity during store");
    a_idle_desel: assert property (cmd_ready |-> chip_sel_n && !data_io_oe) else $error("selected while idle");
    a_boot_wait: assert property ($rose(rst_n) |-> (chip_sel_n && wr_en_n)[*8])
        else $error("access in boot");
    a_recall_cs: assert property ($fell(chip_sel_n) && !out_en_n && !nv_sel_n
        |-> wr_en_n && $stable(out_en_n)) else $error("recall order wrong");
    cover property ($rose(sgo));
    cover property ($fell(chip_sel_n) && !out_en_n && !nv_sel_n);
    cover property (wr ##1 !wr);
endmodule // nvc_chk
bind nvc_ctrl nvc_chk u_chk (.clk, .rst_n, .cmd_ready, .chip_sel_n, .out_en_n, .wr_en_n, .nv_sel_n, .data_io_oe,
    .byte_addr);
`default_nettype wire

// [bench/nvc_mem.sv]
// behavioural nvsram: sram array with shadow copy, store and recall
// sampled on the bench clock; pin level resolved here
`timescale 1ns/100ps
`default_nettype none
module nvc_mem #(
    parameter int BUSY = 16
) (
    input  wire logic        clk,
    input  wire logic        low_vcc,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        wr_en_n,
    input  wire logic        nv_sel_n,
    input  wire logic        data_io_oe,
    input  wire logic [12:0] byte_addr,
    input  wire logic [7:0]  data_io_out,
    output logic      [7:0]  data_io_in
);
    logic [7:0] sram [8192], nv [8192], flt = 8'h00;
    int busy = BUSY;
    logic st0 = 1'b0, rc0 = 1'b0;
    wire st = !nv_sel_n && !chip_sel_n && !wr_en_n && out_en_n;
    wire rc = !nv_sel_n && !chip_sel_n && !out_en_n && wr_en_n;
    wire rd = !chip_sel_n && !out_en_n && wr_en_n && nv_sel_n && busy == 0;
    assign data_io_in = data_io_oe ? data_io_out : rd ? sram[byte_addr] : flt;
    initial for (int i = 0; i < 8192; i++) begin
        nv[i] = i[7:0] ^ 8'h5A;
        sram[i] = nv[i];
    end
    always @(posedge clk) begin
        flt <= ~data_io_in;
        st0 <= st;
        rc0 <= rc;
        if (busy > 0) busy <= busy - 1;
        else if (st && !st0) begin
            busy <= BUSY;
            if (!low_vcc) for (int i = 0; i < 8192; i++) nv[i] <= sram[i];
        end else if (rc && !rc0) begin
            busy <= BUSY;
            for (int i = 0; i < 8192; i++) sram[i] <= nv[i];
        end else if (!chip_sel_n && !wr_en_n && nv_sel_n) sram[byte_addr] <= data_io_in;
    end
endmodule // nvc_mem
`default_nettype wire

// [bench/nvc_ctrl_tb.sv]
// self-checking bench for nvc_ctrl against the behavioural nvsram
// needs nvc_mem and the bound checker
`timescale 1ns/100ps
`default_nettype none
module nvc_ctrl_tb;
    logic        clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, low_vcc = 1'b0;
    logic [1:0]  cmd_op = 2'h0;
    logic [12:0] cmd_addr = 13'h0000, av [8];
    logic [7:0]  cmd_wdata = 8'h00, dv [8];
    wire         cmd_ready, rsp_valid, chip_sel_n, out_en_n, wr_en_n, nv_sel_n, data_io_oe;
    wire  [7:0]  rsp_rdata, data_io_in, data_io_out;
    wire  [12:0] byte_addr;
    int          n_errors = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    nvc_ctrl #(.STORE_CYC(40'h14), .RECALL_CYC(40'h14), .RESTORE_CYC(40'h14)) uut (.clk, .rst_n, .cmd_valid,
        .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .byte_addr, .chip_sel_n, .out_en_n,
        .wr_en_n, .nv_sel_n, .data_io_in, .data_io_out, .data_io_oe);
    nvc_mem u_mem (.clk, .low_vcc, .chip_sel_n, .out_en_n, .wr_en_n, .nv_sel_n, .data_io_oe, .byte_addr,
        .data_io_out, .data_io_in);
    function automatic logic [7:0] pat(logic [12:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task print_verdict;
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task op(input logic [1:0] o, input logic [12:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_addr <= a;
        cmd_wdata <= d;
        do @(negedge clk); while (cmd_ready !== 1'b1 && ++k < 200);
        @(posedge clk);
        cmd_valid <= 1'b0;
        do @(negedge clk); while (rsp_valid !== 1'b1 && ++k < 200);
        if (k >= 200) begin
            n_errors++;
            print_verdict;
        end
    endtask
    task rd(input logic [12:0] a, input logic [7:0] e);
        op(2'h0, a, 8'h00);
        chk(rsp_rdata, e);
    endtask
    initial begin
        void'($urandom(90));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            av[i] = {i[2:0], 10'($urandom)};
            dv[i] = 8'($urandom);
        end
        av[0] = 13'h0000;
        av[7] = 13'h1FFF;
        foreach (av[i]) rd(av[i], pat(av[i]));
        foreach (av[i]) op(2'h1, av[i], dv[i]);
        foreach (av[i]) rd(av[i], dv[i]);
        op(2'h2, 13'h0000, 8'h00);
        foreach (av[i]) op(2'h1, av[i], ~dv[i]);
        low_vcc <= 1'b1;
        op(2'h2, 13'h0000, 8'h00);
        low_vcc <= 1'b0;
        foreach (av[i]) rd(av[i], ~dv[i]);
        op(2'h3, 13'h0000, 8'h00);
        foreach (av[i]) rd(av[i], dv[i]);
        op(2'h3, 13'h0000, 8'h00);
        rd(av[3], dv[3]);
        print_verdict;
    end
endmodule // nvc_ctrl_tb
`default_nettype wire
